/* shared/isw_pkg.sv */
// status word builder constants: data item tags, field positions, codes.
// assumes: used by the builder core; its sticky-flag helper does not reference it.
//
// What this block does
// - extended status item is 32 bits, tagged 0xe020
// - short status item is 8 bits, tagged 0xe010, equals legacy status byte
// - extended word bits 0..7 equal the short status byte
// - bit 0 set when latest host-requested self-test passed, else clear
// - bit 1 high while filter input reliable; drops on any sensor over range
// - satellite variant: fusion-valid also cleared after long receiver invalidity
// - bits 3..4: 11 running, 10 rotation sticky, 01 rejects sticky, 00 done
// - per-axis saturation flags: accel 8..10, gyro 11..13, mag 14..16
// - bit 19 is the OR of saturation flags 8..16
// - bit 21 rises when a sync input event is detected
// - bit 22 high while sync output is active
// - satellite variant fusion mode bits 23..25: 000, 001 coasting, 011 aided
// - bit 20 and bits 26..31 are reserved
package isw_pkg;
   localparam logic [15:0] ID_SHORT_STATUS = 16'he010;
   localparam logic [15:0] ID_EXTENDED_STATUS = 16'he020;
   localparam int SHORT_W = 8;
   localparam int EXT_W = 32;
   localparam int BIT_SELF_TEST = 0;
   localparam int BIT_FUSION_VALID = 1;
   localparam int BIT_SAT_FIX = 2;
   localparam int POS_STATIONARY = 3;
   localparam int POS_SATURATION = 8;
   localparam int NUM_AXES = 9;
   localparam int BIT_SAT_SUMMARY = 19;
   localparam int BIT_SYNC_IN = 21;
   localparam int BIT_SYNC_OUT = 22;
   localparam int POS_FUSION_MODE = 23;
   localparam logic [EXT_W-1:0] EXT_RESET = 32'h0000_0000;
   localparam logic [SHORT_W-1:0] SHORT_RESET = 8'h00;
   // satellite invalid period: no figure given, 10 s is a plain default
   localparam longint SAT_LOSS_MS = 10000;
   localparam longint COAST_MS = 60000;
   localparam longint CLK_MHZ = 125;
   localparam longint SAT_LOSS_CYC = SAT_LOSS_MS * 1000 * CLK_MHZ;
   localparam longint COAST_CYC = COAST_MS * 1000 * CLK_MHZ;
   typedef enum logic [1:0] {
      ISW_ST_DONE_OK = 2'h0,
      ISW_ST_REJECTS = 2'h1,
      ISW_ST_ROTATION = 2'h2,
      ISW_ST_RUNNING = 2'h3
   } isw_stat_e;
   typedef enum logic [2:0] {
      ISW_FM_NO_SAT = 3'h0,
      ISW_FM_COAST = 3'h1,
      ISW_FM_AIDED = 3'h3
   } isw_mode_e;
endpackage

/* core/isw_sticky.sv */
// one sticky flag: set wins over clear.
// assumes: set and clear are synchronous to clk.
`timescale 1ns/1ps
module isw_sticky (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // control
   input wire logic set,
   input wire logic clr,
   // state
   output logic flag_q
);
   logic flag_d;
   assign flag_d = set ? 1'b1 : (clr ? 1'b0 : flag_q);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) flag_q <= 1'b0;
      else if (ce) flag_q <= flag_d;
   end
endmodule

/* core/isw_builder.sv */
// status byte and extended status word builder.
// assumes: condition inputs come from filter logic on clk; sync_in_pin is async.
`timescale 1ns/1ps
module isw_builder #(
   parameter bit SAT_VARIANT = 1'b1,
   parameter longint SAT_LOSS_CYCLES = isw_pkg::SAT_LOSS_CYC,
   parameter longint COAST_CYCLES = isw_pkg::COAST_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // self-test
   input wire logic self_test_done,
   input wire logic self_test_pass,
   // filter and satellite
   input wire logic filter_input_ok,
   input wire logic sat_status_valid,
   input wire logic satellite_fix_flag,
   // stationary estimation
   input wire logic stationary_estimation_command,
   input wire logic stat_rotation_seen,
   input wire logic stat_sample_rejected,
   input wire logic stat_finished,
   // saturation, order accel xyz, gyro xyz, mag xyz
   input wire logic [8:0] axis_over_range,
   // sync
   input wire logic sync_in_pin,
   input wire logic sync_marker_clear,
   input wire logic sync_out_active,
   // status items
   output logic [15:0] short_item_id_q,
   output logic [7:0] short_status_q,
   output logic [15:0] ext_item_id_q,
   output logic [31:0] extended_status_q
);
   initial begin
      if (SAT_LOSS_CYCLES < 1 || COAST_CYCLES < 1) $error("isw_builder: counts must be >= 1");
   end

   // =========================================
   // sync input synchroniser and edge
   logic sync_m_q, sync_s_q, sync_p_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_m_q <= 1'b0;
         sync_s_q <= 1'b0;
         sync_p_q <= 1'b0;
      end else if (ce) begin
         sync_m_q <= sync_in_pin;
         sync_s_q <= sync_m_q;
         sync_p_q <= sync_s_q;
      end
   end
   wire sync_event = sync_s_q & ~sync_p_q;

   // =========================================
   // self-test result, latched per completed run
   logic st_pass_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) st_pass_q <= 1'b0;
      else if (ce && self_test_done) st_pass_q <= self_test_pass;
   end

   // =========================================
   // satellite invalid timer and coasting timer
   logic [63:0] loss_cnt_q, coast_cnt_q;
   logic sat_lost_q, coasting_q, fix_prev_q;
   wire loss_hit = loss_cnt_q >= 64'(SAT_LOSS_CYCLES - 1);
   wire coast_hit = coast_cnt_q >= 64'(COAST_CYCLES - 1);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         loss_cnt_q <= 64'h0;
         sat_lost_q <= 1'b0;
         coast_cnt_q <= 64'h0;
         coasting_q <= 1'b0;
         fix_prev_q <= 1'b0;
      end else if (ce) begin
         fix_prev_q <= satellite_fix_flag;
         if (sat_status_valid) begin
            loss_cnt_q <= 64'h0;
            sat_lost_q <= 1'b0;
         end else if (loss_hit) sat_lost_q <= 1'b1;
         else loss_cnt_q <= loss_cnt_q + 64'h1;
         if (satellite_fix_flag) begin
            coasting_q <= 1'b0;
            coast_cnt_q <= 64'h0;
         end else if (fix_prev_q) begin
            coasting_q <= 1'b1;
            coast_cnt_q <= 64'h0;
         end else if (coasting_q) begin
            if (coast_hit) coasting_q <= 1'b0;
            else coast_cnt_q <= coast_cnt_q + 64'h1;
         end
      end
   end

   // =========================================
   // stationary estimation state
   isw_pkg::isw_stat_e stat_q, stat_d;
   always_comb begin
      stat_d = stat_q;
      case (stat_q)
         isw_pkg::ISW_ST_RUNNING: begin
            if (stat_rotation_seen) stat_d = isw_pkg::ISW_ST_ROTATION;
            else if (stat_finished) stat_d = stat_sample_rejected ?
               isw_pkg::ISW_ST_REJECTS : isw_pkg::ISW_ST_DONE_OK;
         end
         default: begin
            // 10 and 01 stay until the next command
            if (stationary_estimation_command) stat_d = isw_pkg::ISW_ST_RUNNING;
         end
      endcase
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) stat_q <= isw_pkg::ISW_ST_DONE_OK;
      else if (ce) stat_q <= stat_d;
   end

   // =========================================
   // sync input marker, held until acknowledged
   logic sync_mark_q;
   isw_sticky u_sync_mark (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .set(sync_event),
      .clr(sync_marker_clear),
      .flag_q(sync_mark_q)
   );

   // =========================================
   // word assembly
   wire sat_any = |axis_over_range;
   wire fusion_valid = filter_input_ok & ~sat_any & ~(SAT_VARIANT & sat_lost_q);
   wire [2:0] mode_w = !SAT_VARIANT ? 3'h0 :
      satellite_fix_flag ? 3'(isw_pkg::ISW_FM_AIDED) :
      coasting_q ? 3'(isw_pkg::ISW_FM_COAST) : 3'(isw_pkg::ISW_FM_NO_SAT);
   logic [7:0] short_d;
   logic [31:0] ext_d;
   always_comb begin
      short_d = isw_pkg::SHORT_RESET;
      short_d[isw_pkg::BIT_SELF_TEST] = st_pass_q;
      short_d[isw_pkg::BIT_FUSION_VALID] = fusion_valid;
      short_d[isw_pkg::BIT_SAT_FIX] = SAT_VARIANT & satellite_fix_flag;
      short_d[isw_pkg::POS_STATIONARY +: 2] = stat_d;
      ext_d = isw_pkg::EXT_RESET;
      ext_d[7:0] = short_d;
      ext_d[isw_pkg::POS_SATURATION +: isw_pkg::NUM_AXES] = axis_over_range;
      ext_d[isw_pkg::BIT_SAT_SUMMARY] = sat_any;
      ext_d[isw_pkg::BIT_SYNC_IN] = sync_mark_q | sync_event;
      ext_d[isw_pkg::BIT_SYNC_OUT] = sync_out_active;
      ext_d[isw_pkg::POS_FUSION_MODE +: 3] = mode_w;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         short_status_q <= isw_pkg::SHORT_RESET;
         extended_status_q <= isw_pkg::EXT_RESET;
         short_item_id_q <= 16'h0;
         ext_item_id_q <= 16'h0;
      end else if (ce) begin
         short_status_q <= short_d;
         extended_status_q <= ext_d;
         short_item_id_q <= isw_pkg::ID_SHORT_STATUS;
         ext_item_id_q <= isw_pkg::ID_EXTENDED_STATUS;
      end
   end

   // =========================================
   // checks
   a_low_byte_match: assert property (@(posedge clk) disable iff (!rst_n)
      extended_status_q[7:0] == short_status_q)
      else $error("low byte differs from short status");
   a_summary_or: assert property (@(posedge clk) disable iff (!rst_n)
      extended_status_q[19] == |extended_status_q[16:8])
      else $error("summary bit not OR of axis flags");
   a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
      extended_status_q[20] == 1'b0 && extended_status_q[31:26] == 6'h0)
      else $error("reserved bits not zero");
   a_unknown_fields_zero: assert property (@(posedge clk) disable iff (!rst_n)
      extended_status_q[7:5] == 3'h0 && extended_status_q[18:17] == 2'h0)
      else $error("blank fields not zero");
   a_axis_copy: assert property (@(posedge clk) disable iff (!rst_n)
      ce |=> extended_status_q[16:8] == $past(axis_over_range))
      else $error("axis flags not copied");
   a_valid_drops: assert property (@(posedge clk) disable iff (!rst_n)
      ce && (|axis_over_range) |=> !short_status_q[1])
      else $error("fusion valid held during saturation");
   a_selftest_track: assert property (@(posedge clk) disable iff (!rst_n)
      ce && self_test_done ##1 ce |=> short_status_q[0] == $past(self_test_pass, 2))
      else $error("self-test bit wrong");
   a_sync_out_follow: assert property (@(posedge clk) disable iff (!rst_n)
      ce |=> extended_status_q[22] == $past(sync_out_active))
      else $error("sync out marker wrong");
   a_sync_in_rise: assert property (@(posedge clk) disable iff (!rst_n)
      ce && sync_event |=> extended_status_q[21])
      else $error("sync in marker missed");
   a_mode_legal: assert property (@(posedge clk) disable iff (!rst_n)
      extended_status_q[25:23] inside {3'h0, 3'h1, 3'h3})
      else $error("illegal fusion mode");
   a_fix_mode: assert property (@(posedge clk) disable iff (!rst_n)
      short_status_q[2] |-> extended_status_q[25:23] == 3'h3)
      else $error("fix without aided mode");
   a_stat_start: assert property (@(posedge clk) disable iff (!rst_n)
      ce && stat_q != isw_pkg::ISW_ST_RUNNING && stationary_estimation_command
      |=> short_status_q[4:3] == 2'h3)
      else $error("stationary run not shown");
   a_item_ids: assert property (@(posedge clk) disable iff (!rst_n)
      ce |=> short_item_id_q == isw_pkg::ID_SHORT_STATUS && ext_item_id_q == isw_pkg::ID_EXTENDED_STATUS)
      else $error("status item tags wrong");
   a_loss_invalid: assert property (@(posedge clk) disable iff (!rst_n)
      ce && SAT_VARIANT && sat_lost_q |=> !short_status_q[1])
      else $error("fusion valid held after receiver loss");
   a_rotation_sticky: assert property (@(posedge clk) disable iff (!rst_n)
      ce && stat_q == isw_pkg::ISW_ST_ROTATION && !stationary_estimation_command
      |=> short_status_q[4:3] == 2'h2)
      else $error("rotation status not sticky");
   a_sync_clear: assert property (@(posedge clk) disable iff (!rst_n)
      ce && sync_mark_q && sync_marker_clear && !sync_event ##1 ce && !sync_event
      |=> !extended_status_q[21])
      else $error("sync in marker not cleared");
   c_saturation: cover property (@(posedge clk) disable iff (!rst_n) extended_status_q[19]);
   c_sync_in: cover property (@(posedge clk) disable iff (!rst_n) extended_status_q[21]);
   c_rotation: cover property (@(posedge clk) disable iff (!rst_n) short_status_q[4:3] == 2'h2);
   c_coast: cover property (@(posedge clk) disable iff (!rst_n) extended_status_q[25:23] == 3'h1);
endmodule

/* dv/isw_host_model.sv */
// host side model: latches the status items as one output message would carry them.
// assumes: the builder registers its items on clk; the host reads every sample.
`timescale 1ns/1ps
module isw_host_model (
   // clock
   input wire logic clk,
   // items from the device
   input wire logic [7:0] short_byte,
   input wire logic [31:0] ext_word,
   // what the host saw
   output logic [31:0] seen_word,
   output logic seen_pair_ok
);
   // ==========================================
   // message capture
   // both items come from one sample, so the byte must match the word's low end
   always_ff @(posedge clk) begin
      seen_word <= ext_word;
      seen_pair_ok <= (ext_word[7:0] === short_byte);
   end
endmodule

/* dv/imu_status_word_builder_bench.sv */
// self-checking bench for the status word builder.
// assumes: isw_pkg compiled first; short sim counts for satellite timers.
`timescale 1ns/1ps
module imu_status_word_builder_bench;
   // ==========================================
   // stimulus and observation
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic st_done = 1'b0, st_pass = 1'b0, filt_ok = 1'b1, sat_ok = 1'b1, fix = 1'b0;
   logic cmd = 1'b0, rot = 1'b0, rej = 1'b0, fin = 1'b0;
   logic [8:0] axis = 9'h000;
   logic sync_pin = 1'b0, sync_clr = 1'b0, sync_out = 1'b0;
   logic [15:0] sid, eid;
   logic [7:0] sbyte;
   logic [31:0] ext, host_word;
   logic host_ok;
   int failures = 0;
   int n_checks = 0;
   always #4 clk = ~clk;
   isw_builder #(.SAT_VARIANT(1'b1), .SAT_LOSS_CYCLES(20), .COAST_CYCLES(50)) u_dut (
      .clk(clk), .rst_n(rst_n), .ce(ce), .self_test_done(st_done),
      .self_test_pass(st_pass), .filter_input_ok(filt_ok), .sat_status_valid(sat_ok),
      .satellite_fix_flag(fix), .stationary_estimation_command(cmd),
      .stat_rotation_seen(rot), .stat_sample_rejected(rej), .stat_finished(fin),
      .axis_over_range(axis), .sync_in_pin(sync_pin), .sync_marker_clear(sync_clr),
      .sync_out_active(sync_out), .short_item_id_q(sid), .short_status_q(sbyte),
      .ext_item_id_q(eid), .extended_status_q(ext));
   isw_host_model u_host (.clk(clk), .short_byte(sbyte), .ext_word(ext),
      .seen_word(host_word), .seen_pair_ok(host_ok));
   // ==========================================
   // shared tasks
   // inputs change on falling edges only, so each tick lands one registered update
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic conclude();
      if (failures == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ==========================================
   // scenarios
   task automatic t_idle();
      chk("short id", {16'h0, sid}, 32'he010);
      chk("ext id", {16'h0, eid}, 32'he020);
      chk("reserved", ext & 32'hfc1600e0, 32'h0);
      chk("idle word", ext, 32'h0000_0002);
      chk("byte pair", host_ok, 1);
   endtask
   task automatic t_self_test();
      st_pass = 1'b1;
      st_done = 1'b1;
      tick(1);
      st_done = 1'b0;
      // result is latched first, then registered into the byte: two edges
      tick(1);
      chk("self pass", ext[0], 1);
      st_pass = 1'b0;
      tick(2);
      chk("self hold", sbyte[0], 1);
      st_done = 1'b1;
      tick(1);
      st_done = 1'b0;
      tick(1);
      chk("self fail", ext[0], 0);
   endtask
   task automatic t_saturation();
      for (int i = 0; i < 9; i++) begin
         axis = 9'h001 << i;
         tick(1);
         chk("axis flag", {23'h0, ext[16:8]}, 32'h1 << i);
         chk("clip sum", ext[19], 1);
         chk("valid drop", ext[1], 0);
         chk("pair", host_ok, 1);
      end
      axis = 9'h000;
      tick(1);
      chk("clip clear", ext[19], 0);
      chk("valid back", ext[1], 1);
   endtask
   task automatic t_stationary();
      cmd = 1'b1;
      tick(1);
      cmd = 1'b0;
      chk("run", ext[4:3], 3);
      rej = 1'b1;
      fin = 1'b1;
      tick(1);
      fin = 1'b0;
      rej = 1'b0;
      tick(3);
      chk("rejects sticky", sbyte[4:3], 1);
      cmd = 1'b1;
      tick(1);
      cmd = 1'b0;
      rot = 1'b1;
      tick(1);
      rot = 1'b0;
      tick(3);
      chk("rotation sticky", ext[4:3], 2);
      cmd = 1'b1;
      tick(1);
      cmd = 1'b0;
      fin = 1'b1;
      tick(1);
      fin = 1'b0;
      chk("done ok", ext[4:3], 0);
   endtask
   task automatic t_sync();
      sync_pin = 1'b1;
      tick(5);
      sync_pin = 1'b0;
      chk("sync in", ext[21], 1);
      tick(4);
      chk("sync kept", ext[21], 1);
      sync_clr = 1'b1;
      tick(1);
      sync_clr = 1'b0;
      // marker flop clears first, the word follows one edge later
      tick(1);
      chk("sync cleared", ext[21], 0);
      sync_out = 1'b1;
      tick(1);
      chk("sync out", ext[22], 1);
      sync_out = 1'b0;
      tick(1);
      chk("sync out off", ext[22], 0);
   endtask
   task automatic t_satellite();
      fix = 1'b1;
      tick(1);
      chk("fix", ext[2], 1);
      chk("aided", ext[25:23], 3);
      fix = 1'b0;
      tick(3);
      chk("coast", ext[25:23], 1);
      tick(60);
      chk("no sat", ext[25:23], 0);
      sat_ok = 1'b0;
      tick(30);
      chk("loss valid", ext[1], 0);
      sat_ok = 1'b1;
   endtask
   task automatic t_freeze();
      ce = 1'b0;
      axis = 9'h100;
      tick(3);
      chk("frozen", ext[16], 0);
      ce = 1'b1;
      tick(1);
      chk("thawed", host_word[16], 0);
      chk("thawed word", ext[16], 1);
      axis = 9'h000;
      tick(1);
   endtask
   // ==========================================
   // main sequence
   initial begin
      repeat (12) @(posedge clk);
      tick(1);
      chk("in reset", ext, 32'h0);
      chk("reset byte", {24'h0, sbyte}, 32'h0);
      chk("reset ids", {sid, eid}, 32'h0);
      rst_n = 1'b1;
      tick(2);
      t_idle();
      t_self_test();
      t_saturation();
      t_stationary();
      t_sync();
      t_satellite();
      t_freeze();
      conclude();
   end
endmodule
